// ---- msc_cycler.sv ----
// stage sequencer for automatic circulating operation
// assumes settings are static while running; terminals already debounced
`timescale 1ns/1ps
module msc_cycler
    import msc_pkg::*;
(
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rstn_i,
    // mode settings
    input  wire logic [1:0]             control_source_select_i,
    input  wire logic [3:0]             speed_source_select_i,
    input  wire logic [1:0]             multi_speed_mode_select_i,
    input  wire logic [2:0]             cycle_stage_count_i,
    input  wire logic [CW-1:0]          cycle_repeat_count_i,
    input  wire logic                   cycle_end_action_i,
    input  wire logic [TW-1:0]          direction_dead_time_i,
    input  wire logic [2:0]             terminal_control_style_i,
    // per-stage settings, stage 0 is the first speed
    input  wire logic [STAGES*TW-1:0]   stage_accel_i,
    input  wire logic [STAGES*TW-1:0]   stage_decel_i,
    input  wire logic [STAGES*TW-1:0]   stage_run_time_i,
    input  wire logic [STAGES*FW-1:0]   stage_freq_i,
    input  wire logic [STAGES-1:0]      keypad_direction_select_i,
    input  wire logic [STAGES*TW-1:0]   stage_stop_wait_time_i,
    // commands; terminals are high when tied to common
    input  wire logic                   key_run_i,
    input  wire logic                   key_stop_i,
    input  wire logic                   run_terminal_i,
    input  wire logic                   stop_terminal_i,
    input  wire logic                   forward_run_terminal_i,
    input  wire logic                   backward_run_terminal_i,
    input  wire logic                   third_wire_terminal_i,
    // drive outputs
    output logic                        active_o,
    output logic                        drive_on_o,
    output logic                        dir_o,
    output logic [FW-1:0]               freq_o,
    output logic [TW-1:0]               accel_o,
    output logic [TW-1:0]               decel_o,
    output logic [SW-1:0]               stage_o,
    output logic [CW-1:0]               cycles_o
);
    logic r1_q, rst_n;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r1_q  <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            r1_q  <= 1'b1;
            rst_n <= r1_q;
        end
    end

    msc_state_t    st_q, st_d;
    logic [SW-1:0] stg_q, stg_d;
    logic [CW-1:0] cyc_q, cyc_d;
    logic          dir_q, dir_d;
    logic          ld;
    logic [TW-1:0] ld_val;
    logic          tmr_done;
    logic          enabled, start, stop, term_dir;
    logic [SW-1:0] last, nxt;
    logic          wrap, nxt_dir;
    logic [TW-1:0] stage_wait [STAGES];
    logic [TW-1:0] stage_run  [STAGES];
    logic [TW-1:0] stage_acc  [STAGES];
    logic [TW-1:0] stage_dec  [STAGES];
    logic [FW-1:0] stage_frq  [STAGES];

    genvar g;
    generate
        for (g = 0; g < STAGES; g++) begin : g_unpack
            assign stage_wait[g] = stage_stop_wait_time_i[g*TW +: TW];
            assign stage_run[g]  = stage_run_time_i[g*TW +: TW];
            assign stage_acc[g]  = stage_accel_i[g*TW +: TW];
            assign stage_dec[g]  = stage_decel_i[g*TW +: TW];
            assign stage_frq[g]  = stage_freq_i[g*FW +: FW];
        end
    endgenerate

    msc_timer u_tmr (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .load_i  (ld),
        .ticks_i (ld_val),
        .done_o  (tmr_done)
    );

    assign enabled = (speed_source_select_i == SPD_MULTI)
                  && (multi_speed_mode_select_i == MODE_CYCLE);
    // inputs active high = tied to common
    assign start = key_run_i || run_terminal_i;
    assign stop  = key_stop_i || stop_terminal_i;

    // two-line styles follow which terminal is closed; others use the
    // third wire to pick direction, ignoring the forward and backward terminals
    always_comb begin
        unique case (terminal_control_style_i)
            TS_2LINE1, TS_2LINE2: term_dir = backward_run_terminal_i && !forward_run_terminal_i;
            default:              term_dir = third_wire_terminal_i ? DIR_REV : DIR_FWD;
        endcase
    end

    // clamp stage count to the allowed window
    assign last = (cycle_stage_count_i < STG_MIN) ? STG_MIN - 3'h1 :
                  (cycle_stage_count_i - 3'h1);
    assign wrap = (stg_q >= last);
    assign nxt  = wrap ? '0 : stg_q + SW'(1);

    function automatic logic dir_of(input logic [SW-1:0] s);
        if (control_source_select_i == SRC_TERM) begin
            return term_dir;
        end
        return keypad_direction_select_i[s];
    endfunction
    // process form so setting changes read inside dir_of re-evaluate it
    always_comb begin
        nxt_dir = dir_of(nxt);
    end

    always_comb begin
        st_d   = st_q;
        stg_d  = stg_q;
        cyc_d  = cyc_q;
        dir_d  = dir_q;
        ld     = 1'b0;
        ld_val = '0;
        unique case (st_q)
            ST_IDLE, ST_HOLD: begin
                if (st_q == ST_HOLD && stop) begin
                    st_d  = ST_IDLE;
                    stg_d = '0;
                    cyc_d = '0;
                end else if (st_q == ST_IDLE && start && enabled && !stop) begin
                    st_d   = ST_RUN;
                    stg_d  = '0;
                    cyc_d  = '0;
                    dir_d  = dir_of('0);
                    ld     = 1'b1;
                    ld_val = stage_run[0];
                end
            end
            ST_RUN: begin
                if (tmr_done) begin
                    if (wrap && (cyc_q + CW'(1) >= cycle_repeat_count_i)) begin
                        cyc_d = cyc_q + CW'(1);
                        st_d  = (cycle_end_action_i == END_STOP) ? ST_IDLE : ST_HOLD;
                        if (cycle_end_action_i == END_STOP) begin
                            stg_d = '0;
                            cyc_d = '0;
                        end
                    end else begin
                        if (wrap) begin
                            cyc_d = cyc_q + CW'(1);
                        end
                        stg_d = nxt;
                        if (nxt_dir != dir_q) begin
                            st_d   = ST_STOP;
                            ld     = 1'b1;
                            ld_val = stage_wait[stg_q];
                        end else if (stage_wait[stg_q] != '0) begin
                            st_d   = ST_WAIT;
                            ld     = 1'b1;
                            ld_val = stage_wait[stg_q];
                        end else begin
                            st_d   = ST_RUN;
                            ld     = 1'b1;
                            ld_val = stage_run[nxt];
                        end
                    end
                end
            end
            ST_WAIT: begin
                if (tmr_done) begin
                    st_d   = ST_RUN;
                    ld     = 1'b1;
                    ld_val = stage_run[stg_q];
                end
            end
            ST_STOP: begin
                if (tmr_done) begin
                    st_d   = ST_DEAD;
                    ld     = 1'b1;
                    ld_val = direction_dead_time_i;
                end
            end
            ST_DEAD: begin
                if (tmr_done) begin
                    st_d   = ST_RUN;
                    dir_d  = dir_of(stg_q);
                    ld     = 1'b1;
                    ld_val = stage_run[stg_q];
                end
            end
            default: st_d = ST_IDLE;
        endcase
        // stop wins over every running state
        if (stop && st_q != ST_IDLE) begin
            st_d  = ST_IDLE;
            stg_d = '0;
            cyc_d = '0;
            ld    = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_q  <= ST_IDLE;
            stg_q <= '0;
            cyc_q <= '0;
            dir_q <= DIR_FWD;
        end else begin
            st_q  <= st_d;
            stg_q <= stg_d;
            cyc_q <= cyc_d;
            dir_q <= dir_d;
        end
    end

    // drive outputs registered from next stage (stg_d), so they line up with the current stage
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            active_o   <= 1'b0;
            drive_on_o <= 1'b0;
            dir_o      <= DIR_FWD;
            freq_o     <= '0;
            accel_o    <= '0;
            decel_o    <= '0;
            stage_o    <= '0;
            cycles_o   <= '0;
        end else begin
            active_o   <= (st_d != ST_IDLE);
            drive_on_o <= (st_d == ST_RUN) || (st_d == ST_HOLD);
            dir_o      <= dir_d;
            freq_o     <= stage_frq[stg_d];
            accel_o    <= stage_acc[stg_d];
            decel_o    <= stage_dec[stg_d];
            stage_o    <= stg_d;
            cycles_o   <= cyc_d;
        end
    end

    property p_stop_ends;
        @(posedge clk_i) disable iff (!rst_n)
        (stop && st_q != ST_IDLE) |=> (st_q == ST_IDLE && stg_q == '0 && cyc_q == '0);
    endproperty
    a_stop_ends: assert property (p_stop_ends) else $error("stop did not end cycling");

    property p_enable;
        @(posedge clk_i) disable iff (!rst_n)
        (st_q == ST_IDLE && !enabled) |=> (st_q == ST_IDLE);
    endproperty
    a_enable: assert property (p_enable) else $error("started while not enabled");

    property p_dead_after_stop;
        @(posedge clk_i) disable iff (!rst_n)
        (st_q == ST_STOP && tmr_done && !stop) |=> (st_q == ST_DEAD);
    endproperty
    a_dead_after_stop: assert property (p_dead_after_stop) else $error("no dead time");

    property p_drive_off_wait;
        @(posedge clk_i) disable iff (!rst_n)
        (st_q == ST_WAIT || st_q == ST_DEAD || st_q == ST_STOP) |-> !drive_on_o;
    endproperty
    a_drive_off_wait: assert property (p_drive_off_wait) else $error("drive on in pause");

    property p_freq_stage;
        @(posedge clk_i) disable iff (!rst_n)
        (st_q == ST_RUN) |-> (freq_o == stage_frq[stg_q] && stage_o == stg_q);
    endproperty
    a_freq_stage: assert property (p_freq_stage) else $error("frequency not stage's");

    property p_advance;
        @(posedge clk_i) disable iff (!rst_n)
        (st_q == ST_RUN && tmr_done && !stop && !wrap) |=> (stg_q == $past(stg_q) + SW'(1));
    endproperty
    a_advance: assert property (p_advance) else $error("stage did not advance");

    property p_stage_bound;
        @(posedge clk_i) disable iff (!rst_n)
        (st_q != ST_IDLE) |-> (stg_q <= STG_MAX - 3'h1);
    endproperty
    a_stage_bound: assert property (p_stage_bound) else $error("stage beyond seventh");

    property p_direct;
        @(posedge clk_i) disable iff (!rst_n)
        (st_q == ST_RUN && tmr_done && !stop && !wrap && nxt_dir == dir_q
         && stage_wait[stg_q] == '0) |=> (st_q == ST_RUN);
    endproperty
    a_direct: assert property (p_direct) else $error("paused with zero wait");

    property p_term_dir;
        @(posedge clk_i) disable iff (!rst_n)
        (control_source_select_i == SRC_TERM && st_q == ST_IDLE && st_d == ST_RUN)
            |=> (dir_q == $past(term_dir));
    endproperty
    a_term_dir: assert property (p_term_dir) else $error("direction not from terminals");
endmodule

// ---- msc_cycler_tb_top.sv ----
// self-checking bench for the stage cycler
// assumes zero run, wait and dead times: one tick is far too long to simulate
`timescale 1ns/1ps
module msc_cycler_tb_top;
    import msc_pkg::*;
    logic                 clk_i  = 1'b0;
    logic                 rstn_i = 1'b0;
    logic [1:0]           src    = SRC_KEYPAD;
    logic [3:0]           spd    = SPD_MULTI;
    logic [1:0]           mode   = MODE_CYCLE;
    logic [2:0]           n_stg  = 3'h2;
    logic [CW-1:0]        rep    = 16'h0001;
    logic                 hold   = 1'b0;
    logic [2:0]           tsty   = TS_2LINE1;
    logic [STAGES-1:0]    kdir   = '0;
    logic [STAGES-1:0]    xdir   = '0;
    logic [STAGES*TW-1:0] acc, dec;
    logic [STAGES*FW-1:0] frq;
    logic                 kr, ks, rt, st, ft, bt, tw;
    logic                 active, drv, dir;
    logic [FW-1:0]        freq;
    logic [TW-1:0]        acc_o, dec_o;
    logic [SW-1:0]        stage;
    logic [CW-1:0]        cycles;
    logic                 mon_en = 1'b0;
    logic [SW-1:0]        seen[$];
    int                   off_cnt, errors = 0, cmp_count = 0;

    always #5 clk_i = ~clk_i;
    initial for (int k = 0; k < STAGES; k++) begin
        frq[k*FW+:FW] = 16'h0100 + 16'(k);
        acc[k*TW+:TW] = 16'h0200 + 16'(k);
        dec[k*TW+:TW] = 16'h0300 + 16'(k);
    end

    msc_panel_model u_msc_panel_model (.clk_i(clk_i), .key_run_o(kr), .key_stop_o(ks),
        .run_term_o(rt), .stop_term_o(st), .fwd_term_o(ft), .back_term_o(bt),
        .third_term_o(tw));

    msc_cycler u_msc_cycler (.clk_i(clk_i), .rstn_i(rstn_i),
        .control_source_select_i(src), .speed_source_select_i(spd),
        .multi_speed_mode_select_i(mode), .cycle_stage_count_i(n_stg),
        .cycle_repeat_count_i(rep), .cycle_end_action_i(hold),
        .direction_dead_time_i(16'h0000), .terminal_control_style_i(tsty),
        .stage_accel_i(acc), .stage_decel_i(dec), .stage_run_time_i('0),
        .stage_freq_i(frq), .keypad_direction_select_i(kdir), .stage_stop_wait_time_i('0),
        .key_run_i(kr), .key_stop_i(ks), .run_terminal_i(rt), .stop_terminal_i(st),
        .forward_run_terminal_i(ft), .backward_run_terminal_i(bt),
        .third_wire_terminal_i(tw), .active_o(active), .drive_on_o(drv), .dir_o(dir),
        .freq_o(freq), .accel_o(acc_o), .decel_o(dec_o), .stage_o(stage), .cycles_o(cycles));

    task automatic chk_b(input logic got, input logic exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %b want %b", $time, msg, got, exp);
        end
    endtask

    task automatic chk_w(input logic [CW-1:0] got, input logic [CW-1:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask

    // stage values only judged while the output is driven
    always @(negedge clk_i) begin
        if (mon_en && active === 1'b1) begin
            if (drv === 1'b1) begin
                if (seen.size() == 0 || seen[$] !== stage) seen.push_back(stage);
                chk_w(freq, 16'h0100 + CW'(stage), "freq");
                chk_w(acc_o, 16'h0200 + CW'(stage), "accel");
                chk_w(dec_o, 16'h0300 + CW'(stage), "decel");
                chk_b(dir, xdir[stage], "dir");
            end else off_cnt++;
        end
    end

    // full run: start, follow stage order, judge the end state
    task automatic cycle(input string name, input int start, input int n, input int r,
                         input logic h, input logic gaps);
        @(negedge clk_i);
        n_stg = 3'(n);
        rep = CW'(r);
        hold = h;
        seen.delete();
        off_cnt = 0;
        mon_en = 1'b1;
        u_msc_panel_model.pulse(start);
        for (int i = 0; i < 2000 && seen.size() < n * r; i++) @(negedge clk_i);
        repeat (20) @(negedge clk_i);
        mon_en = 1'b0;
        chk_w(CW'(seen.size()), CW'(n * r), "stage visits");
        for (int i = 0; i < seen.size(); i++) chk_w(CW'(seen[i]), CW'(i % n), "order");
        chk_b(active, h, "end action");
        chk_b(off_cnt > 0, gaps, "stop between stages");
        if (h) begin
            chk_w(CW'(stage), CW'(n - 1), "held stage");
            chk_w(cycles, CW'(r), "passes");
            chk_b(drv, 1'b1, "held drive");
        end
        $display("test %s done", name);
    endtask

    task automatic stop_check(input int how);
        u_msc_panel_model.pulse(how);
        repeat (3) @(negedge clk_i);
        chk_b(active, 1'b0, "stopped");
        chk_w(CW'(stage), 16'h0000, "stage cleared");
        chk_w(cycles, 16'h0000, "passes cleared");
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        report_and_stop();
    end

    initial begin
        repeat (5) @(negedge clk_i);
        rstn_i = 1'b1;
        repeat (3) @(negedge clk_i);
        // run is refused unless speed source and mode both select cycling
        for (int i = 0; i < 2; i++) begin
            @(negedge clk_i);
            spd = (i == 0) ? 4'h0 : SPD_MULTI;
            mode = (i == 0) ? MODE_CYCLE : 2'h2;
            u_msc_panel_model.pulse(0);
            repeat (5) @(negedge clk_i);
            chk_b(active, 1'b0, "not enabled");
        end
        @(negedge clk_i);
        mode = MODE_CYCLE;
        $display("test enable done");
        cycle("seven stages", 0, 7, 2, END_STOP, 1'b0);
        kdir = 8'h02;
        xdir = 8'h02;
        cycle("reversal hold", 0, 2, 3, 1'b1, 1'b1);
        stop_check(1);
        src = SRC_REMOTE;
        cycle("remote", 0, 2, 1, END_STOP, 1'b1);
        src = SRC_TERM;
        xdir = 8'hff;
        u_msc_panel_model.tie_dir(1'b0, 1'b1, 1'b0);
        cycle("terminal", 2, 3, 1, 1'b1, 1'b0);
        stop_check(3);
        // third-wire style: direction follows the third terminal
        tsty = 3'h2;
        u_msc_panel_model.tie_dir(1'b1, 1'b0, 1'b1);
        cycle("three wire", 2, 2, 1, END_STOP, 1'b0);
        tsty = TS_2LINE1;
        src = SRC_KEYPAD;
        kdir = '0;
        xdir = '0;
        cycle("mid stop", 0, 7, 1, END_STOP, 1'b0);
        rep = 16'h03e8;
        u_msc_panel_model.pulse(0);
        repeat (30) @(negedge clk_i);
        chk_b(active, 1'b1, "long run");
        stop_check(1);
        $display("test mid stop done");
        report_and_stop();
    end
endmodule

// ---- msc_panel_model.sv ----
// keypad keys and input terminals facing the cycler
// assumes the bench calls its tasks; every change lands on a falling edge
`timescale 1ns/1ps
module msc_panel_model (
    // clock
    input  wire logic clk_i,
    // keys and terminals, high when pressed or tied to common
    output logic      key_run_o,
    output logic      key_stop_o,
    output logic      run_term_o,
    output logic      stop_term_o,
    output logic      fwd_term_o,
    output logic      back_term_o,
    output logic      third_term_o
);
    // open terminals read as zero, tied ones as one
    initial begin
        {key_run_o, key_stop_o, run_term_o, stop_term_o} = 4'h0;
        {fwd_term_o, back_term_o, third_term_o} = 3'h0;
    end

    // one-cycle press: 0 run key, 1 stop key, 2 run terminal, 3 stop terminal
    task automatic pulse(input int which);
        @(negedge clk_i);
        case (which)
            0: key_run_o = 1'b1;
            1: key_stop_o = 1'b1;
            2: run_term_o = 1'b1;
            default: stop_term_o = 1'b1;
        endcase
        @(negedge clk_i);
        {key_run_o, key_stop_o, run_term_o, stop_term_o} = 4'h0;
    endtask

    // direction terminals stay tied for a whole run
    task automatic tie_dir(input logic forward_run_terminal, input logic back, input logic third);
        @(negedge clk_i);
        fwd_term_o = forward_run_terminal;
        back_term_o = back;
        third_term_o = third;
    endtask
endmodule

// ---- msc_pkg.sv ----
// constants and types for the multi-stage speed cycler
// assumes one 100 MHz clock; all settings arrive as plain ports
package msc_pkg;
    localparam int          STAGES     = 8;
    localparam int          SW         = 3;
    localparam int          FW         = 16;
    localparam int          TW         = 16;
    localparam int          CW         = 16;
    // time settings are counted in ticks of this length
    localparam int          TICK_NS    = 1000000;
    localparam int          CLK_NS     = 10;
    localparam int          TICK_CYC   = TICK_NS / CLK_NS;
    localparam logic [1:0]  SRC_KEYPAD = 2'h0;
    localparam logic [1:0]  SRC_TERM   = 2'h1;
    localparam logic [1:0]  SRC_REMOTE = 2'h2;
    localparam logic [3:0]  SPD_MULTI  = 4'h2;
    localparam logic [1:0]  MODE_CYCLE = 2'h1;
    localparam logic [2:0]  STG_MIN    = 3'h2;
    localparam logic [2:0]  STG_MAX    = 3'h7;
    localparam logic [2:0]  TS_2LINE1  = 3'h0;
    localparam logic [2:0]  TS_2LINE2  = 3'h1;
    localparam logic        DIR_FWD    = 1'b0;
    localparam logic        DIR_REV    = 1'b1;
    localparam logic        END_STOP   = 1'b0;
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_RUN  = 6'b000010,
        ST_WAIT = 6'b000100,
        ST_STOP = 6'b001000,
        ST_DEAD = 6'b010000,
        ST_HOLD = 6'b100000
    } msc_state_t;
endpackage

// ---- msc_timer.sv ----
// tick-based countdown used for run, wait and dead time
// assumes reset already synchronised by the caller
`timescale 1ns/1ps
module msc_timer
    import msc_pkg::*;
(
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    // control
    input  wire logic          load_i,
    input  wire logic [TW-1:0] ticks_i,
    // status
    output logic               done_o
);
    logic [31:0]   pre_q, pre_d;
    logic [TW-1:0] cnt_q, cnt_d;
    logic          tick;

    assign tick   = (pre_q == 32'(TICK_CYC - 1));
    // done must not look at load_i: the caller derives load from done
    assign done_o = (cnt_q == '0);

    always_comb begin
        pre_d = tick ? 32'h0 : pre_q + 32'h1;
        cnt_d = cnt_q;
        if (load_i) begin
            pre_d = 32'h0;
            cnt_d = ticks_i;
        end else if (tick && cnt_q != '0) begin
            cnt_d = cnt_q - TW'(1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre_q <= 32'h0;
            cnt_q <= '0;
        end else begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
        end
    end
endmodule
